//--- rtl/esb_host.sv
// esb_host: host end of the three-slot expansion bus.
// assumes card pins are asynchronous; the processor clock drives lnk_clk_i.
// Behaviour
// [R1] data lines idle high by external pull-ups; byte strobes qualify each half
// [R2] twelve word lines plus low/high select reach 8192 words per slot
// [R3] only low 8 address lines stable at strobe; upper 4 by select
// [R4] write: asserted byte strobes mark valid data bytes
// [R5] card acknowledges once its read or write is done
// [R6] read asserted means card drives data; otherwise host drives
// [R7] legacy card asserts peripheral request, never with acknowledge
// [R8] host answers peripheral request with legacy cycle valid
// [R9] E clock high 4, low 6 processor clocks
// [R10] legacy request and valid replace select and acknowledge
// [R11] card takes bus only with incoming grant asserted
// [R12] card not wanting bus passes grant through unchanged
// [R13] owner holds grant owned until giving up the bus
// [R14] card loads high DMA byte from data 5..12 by latch strobe
// [R15] host supplies a buffered 5 MHz reference clock
// [R16] on bus reset every card returns to power-on state
// [R17] card holds interrupt until host acknowledges
// [R18] host acknowledges on that slot's own acknowledge line
// [R19] slot select asserts after address and data strobes are stable
// [R20] no acknowledge within 30 ms ends cycle with bus error
// [R21] write: select means data valid, acknowledge means data taken
// [R22] card should derive acknowledge from select decode
// [R23] non-DMA card ties grant in to grant out
// [R24] card drives data only while selected on a read; the card model also drives it while it owns the bus for the DMA byte load
`default_nettype none
module esb_host import esb_pkg::*; #(
  parameter int TMO_CYC = ESB_TMO_CYC
) (
  // system side
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic lnk_clk_i,
  // command port
  input wire logic cmd_req_i,
  input wire esb_cmd_t cmd_i,
  output logic busy_o,
  output logic rsp_valid_o,
  output esb_rsp_t rsp_o,
  // interrupts
  input wire logic [ESB_NSLOT-1:0] irq_ack_i,
  output logic [ESB_NSLOT-1:0] irq_pending_o,
  // slot address and data
  output logic [ESB_AW-1:0] slot_word_address_lines_o,
  input wire logic [ESB_DW-1:0] slot_data_lines_i,
  output logic [ESB_DW-1:0] slot_data_lines_o,
  output logic slot_data_lines_oe_o,
  // slot control
  output logic addr_strobe_n_o,
  output logic upper_byte_strobe_n_o,
  output logic lower_byte_strobe_n_o,
  output logic read_o,
  input wire logic transfer_ack_n_i,
  input wire logic legacy_periph_req_n_i,
  output logic legacy_cycle_valid_n_o,
  output logic e_clk_o,
  output logic [ESB_NSLOT-1:0] slot_low_area_sel_n_o,
  output logic [ESB_NSLOT-1:0] slot_high_area_sel_n_o,
  // bus arbitration and dma
  input wire logic bus_req_n_i,
  output logic grant_chain_in_n_o,
  input wire logic grant_owned_n_i,
  input wire logic dma_hi_latch_load_n_i,
  output logic [7:0] dma_hi_addr_o,
  output logic dma_active_o,
  // misc
  output logic ref_clk_5m_o,
  output logic bus_reset_n_o,
  input wire logic [ESB_NSLOT-1:0] slot_irq_n_i,
  output logic [ESB_NSLOT-1:0] slot_irq_ack_n_o
);
  localparam int TW = $clog2(TMO_CYC) + 1;
  localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);

  logic bus_rst_n_q, ref_q, req_tgl_q, busy_q, dn_seen_q, rsp_valid_q;
  logic [4:0] rcnt_q;
  logic [1:0] dn_s_q, lrst_q, rq_s_q;
  esb_cmd_t cmd_q;
  esb_rsp_t rsp_out_q, rsp_q;
  esb_pin_t pin_raw, s1_q, s2_q;
  esb_state_t st_q;
  logic lrstn, rq_seen_q, dn_tgl_q, new_req, go;
  logic [3:0] ecnt_q, ecnt_d;
  logic e_q, as_n_q, uds_n_q, lds_n_q, rd_q, vma_n_q, doe_q, grant_n_q, dma_hi_latch_load_n_d1_q, own_q;
  logic [ESB_AW-1:0] addr_q;
  logic [ESB_DW-1:0] dout_q;
  logic [TW-1:0] tmo_q;
  logic [7:0] dma_hi_q;
  logic [ESB_NSLOT-1:0] lo_n_q, hi_n_q, pend_q, iack_n_q;

  // system domain: bus reset, reference clock, command hand-off
  always_ff @(posedge clk_i) begin
    bus_rst_n_q <= rstn_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rcnt_q <= '0;
      ref_q <= 1'b0;
    end else if (rcnt_q == ESB_REF_LAST) begin // see [R15]
      rcnt_q <= '0;
      ref_q <= ~ref_q;
    end else begin
      rcnt_q <= rcnt_q + 5'h1;
    end
  end

  // cmd_q stays frozen while busy, so the link side may read it after the toggle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (cmd_req_i && !busy_q) begin
      cmd_q <= cmd_i;
      req_tgl_q <= ~req_tgl_q;
      busy_q <= 1'b1;
    end else if (dn_s_q[1] != dn_seen_q) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      dn_s_q <= '0;
      dn_seen_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_out_q <= '0;
    end else begin
      dn_s_q <= {dn_s_q[0], dn_tgl_q};
      dn_seen_q <= dn_s_q[1];
      rsp_valid_q <= dn_s_q[1] != dn_seen_q;
      if (dn_s_q[1] != dn_seen_q) begin
        rsp_out_q <= rsp_q;
      end
    end
  end

  // interrupts, one per slot
  for (genvar k = 0; k < ESB_NSLOT; k++) begin : g_irq
    logic [1:0] is_q;
    always_ff @(posedge clk_i) begin
      is_q <= {is_q[0], slot_irq_n_i[k]};
    end
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        pend_q[k] <= 1'b0;
        iack_n_q[k] <= 1'b1;
      end else begin
        pend_q[k] <= !is_q[1];
        // hold the acknowledge until the card drops its request
        if (!pend_q[k]) begin
          iack_n_q[k] <= 1'b1;
        end else if (irq_ack_i[k]) begin // see [R18]
          iack_n_q[k] <= 1'b0;
        end
      end
    end
  end

  // link domain: reset and pin synchronisers
  always_ff @(posedge lnk_clk_i) begin
    lrst_q <= {lrst_q[0], rstn_i};
  end
  assign lrstn = lrst_q[1];

  assign pin_raw = '{d: slot_data_lines_i, ack_n: transfer_ack_n_i,
                     vpa_n: legacy_periph_req_n_i, breq_n: bus_req_n_i,
                     own_n: grant_owned_n_i, dma_hi_latch_load_n_n: dma_hi_latch_load_n_i};

  // data is synchronised with the acknowledge; the card holds it while acking
  always_ff @(posedge lnk_clk_i) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    rq_s_q <= {rq_s_q[0], req_tgl_q};
  end

  assign new_req = rq_s_q[1] != rq_seen_q;
  assign go = (st_q == ST_IDLE) && new_req && s2_q.own_n && grant_n_q;
  assign ecnt_d = (ecnt_q == ESB_E_LAST) ? 4'h0 : ecnt_q + 4'h1;

  always_ff @(posedge lnk_clk_i) begin
    if (!lrstn) begin
      // start at the last low count so the first high phase is a full one
      ecnt_q <= ESB_E_LAST;
      e_q <= 1'b0;
    end else begin
      ecnt_q <= ecnt_d;
      e_q <= ecnt_d < ESB_E_HI; // see [R9]
    end
  end

  // cycle sequencer
  always_ff @(posedge lnk_clk_i) begin
    if (!lrstn) begin
      st_q <= ST_IDLE;
      rq_seen_q <= 1'b0;
      dn_tgl_q <= 1'b0;
      rsp_q <= '0;
      tmo_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            rq_seen_q <= rq_s_q[1];
            st_q <= ST_ADDR;
          end
        end
        ST_ADDR: st_q <= ST_SEL;
        ST_SEL: begin
          tmo_q <= '0;
          st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // acknowledge wins should a card break the exclusion
          if (!s2_q.ack_n) begin // see [R21]
            rsp_q <= '{rdata: s2_q.d, berr: 1'b0, legacy: 1'b0};
            st_q <= ST_END;
          end else if (!s2_q.vpa_n) begin
            st_q <= ST_LEG;
          end else if (tmo_q == TMO_LAST) begin // see [R20]
            rsp_q <= '{rdata: '0, berr: 1'b1, legacy: 1'b0};
            st_q <= ST_END;
          end else begin
            tmo_q <= tmo_q + TW'(1);
          end
        end
        ST_LEG: begin
          if (!vma_n_q && ecnt_q == ESB_E_HI_LAST) begin // see [R10]
            rsp_q <= '{rdata: s2_q.d, berr: 1'b0, legacy: 1'b1};
            st_q <= ST_END;
          end
        end
        ST_END: begin
          dn_tgl_q <= ~dn_tgl_q;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // address, strobes and data drive
  always_ff @(posedge lnk_clk_i) begin
    if (!lrstn) begin
      as_n_q <= 1'b1;
      uds_n_q <= 1'b1;
      lds_n_q <= 1'b1;
      rd_q <= 1'b0;
      addr_q <= '0;
      dout_q <= '0;
      doe_q <= 1'b0;
    end else if (go) begin
      addr_q <= cmd_q.waddr; // see [R2]
      as_n_q <= 1'b0; // see [R3]
      rd_q <= !cmd_q.wr; // see [R6]
      uds_n_q <= !cmd_q.ube; // see [R4]
      lds_n_q <= !cmd_q.lbe;
      dout_q <= cmd_q.wdata;
      doe_q <= cmd_q.wr; // see [R1]
    end else if (st_q == ST_END) begin
      as_n_q <= 1'b1;
      uds_n_q <= 1'b1;
      lds_n_q <= 1'b1;
      rd_q <= 1'b0;
      doe_q <= 1'b0;
    end
  end

  // valid asserts on the same edge that E rises, so the card sees a full high phase
  always_ff @(posedge lnk_clk_i) begin
    if (!lrstn) begin
      vma_n_q <= 1'b1;
    end else if (st_q == ST_LEG && ecnt_q == ESB_E_LAST) begin // see [R8]
      vma_n_q <= 1'b0;
    end else if (st_q == ST_END) begin
      vma_n_q <= 1'b1;
    end
  end

  for (genvar k = 0; k < ESB_NSLOT; k++) begin : g_sel
    always_ff @(posedge lnk_clk_i) begin
      if (!lrstn) begin
        lo_n_q[k] <= 1'b1;
        hi_n_q[k] <= 1'b1;
      end else if (st_q == ST_ADDR) begin // see [R19]
        lo_n_q[k] <= !(cmd_q.slot == 2'(k) && !cmd_q.area);
        hi_n_q[k] <= !(cmd_q.slot == 2'(k) && cmd_q.area);
      end else if (st_q == ST_END) begin
        lo_n_q[k] <= 1'b1;
        hi_n_q[k] <= 1'b1;
      end
    end
  end

  // arbitration: grant only while idle, withdraw once ownership is taken
  always_ff @(posedge lnk_clk_i) begin
    if (!lrstn) begin
      grant_n_q <= 1'b1;
      own_q <= 1'b0;
    end else begin
      own_q <= !s2_q.own_n;
      if (!s2_q.own_n || s2_q.breq_n) begin
        grant_n_q <= 1'b1;
      end else if (st_q == ST_IDLE && !new_req) begin
        grant_n_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (!lrstn) begin
      dma_hi_latch_load_n_d1_q <= 1'b1;
      dma_hi_q <= '0;
    end else begin
      dma_hi_latch_load_n_d1_q <= s2_q.dma_hi_latch_load_n_n;
      if (dma_hi_latch_load_n_d1_q && !s2_q.dma_hi_latch_load_n_n) begin // see [R14]
        dma_hi_q <= s2_q.d[ESB_DMA_MSB:ESB_DMA_LSB];
      end
    end
  end

  assign busy_o = busy_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_o = rsp_out_q;
  assign irq_pending_o = pend_q;
  assign slot_irq_ack_n_o = iack_n_q;
  assign ref_clk_5m_o = ref_q;
  assign bus_reset_n_o = bus_rst_n_q;
  assign slot_word_address_lines_o = addr_q;
  assign slot_data_lines_o = dout_q;
  assign slot_data_lines_oe_o = doe_q;
  assign addr_strobe_n_o = as_n_q;
  assign upper_byte_strobe_n_o = uds_n_q;
  assign lower_byte_strobe_n_o = lds_n_q;
  assign read_o = rd_q;
  assign legacy_cycle_valid_n_o = vma_n_q;
  assign e_clk_o = e_q;
  assign slot_low_area_sel_n_o = lo_n_q;
  assign slot_high_area_sel_n_o = hi_n_q;
  assign grant_chain_in_n_o = grant_n_q;
  assign dma_hi_addr_o = dma_hi_q;
  assign dma_active_o = own_q;

  // checks
  wire sel_any = ~&{lo_n_q, hi_n_q};

  property p_e_shape;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    $rose(e_clk_o) |-> e_clk_o [*4] ##1 !e_clk_o [*6] ##1 e_clk_o;
  endproperty
  a_e_shape: assert property (p_e_shape) else $error("E clock shape wrong"); // see [R9]

  property p_sel_late;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    $rose(sel_any) |-> !addr_strobe_n_o && $past(!addr_strobe_n_o);
  endproperty
  a_sel_late: assert property (p_sel_late) else $error("select before strobe"); // see [R19]

  property p_one_sel;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    $onehot0(~{lo_n_q, hi_n_q});
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects at once"); // see [R2]

  property p_addr_hold;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    !addr_strobe_n_o && $past(!addr_strobe_n_o) |-> $stable(slot_word_address_lines_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle"); // see [R3]

  property p_wr_data;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    !read_o && !(upper_byte_strobe_n_o && lower_byte_strobe_n_o) |-> slot_data_lines_oe_o;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write strobe without data"); // see [R4]

  property p_rd_release;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    read_o |-> !slot_data_lines_oe_o;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("host drives on read"); // see [R6]

  property p_vma_soon;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    st_q == ST_LEG |-> ##[0:10] !legacy_cycle_valid_n_o;
  endproperty
  a_vma_soon: assert property (p_vma_soon) else $error("legacy valid late"); // see [R8]

  property p_vma_cause;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    $fell(legacy_cycle_valid_n_o) |-> sel_any && e_clk_o;
  endproperty
  a_vma_cause: assert property (p_vma_cause) else $error("legacy valid misplaced"); // see [R10]

  property p_tmo;
    @(posedge lnk_clk_i) disable iff (!lrstn)
    st_q == ST_WAIT && tmo_q == TMO_LAST && s2_q.ack_n && s2_q.vpa_n
      |=> st_q == ST_END && rsp_q.berr ##1 st_q == ST_IDLE && sel_any == 1'b0;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not ended"); // see [R20]

  property p_ref;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(ref_clk_5m_o) |-> ##20 $fell(ref_clk_5m_o);
  endproperty
  a_ref: assert property (p_ref) else $error("reference clock half period wrong"); // see [R15]

  property p_iack;
    @(posedge clk_i) disable iff (!rstn_i)
    irq_pending_o[0] && irq_ack_i[0] |=> !slot_irq_ack_n_o[0];
  endproperty
  a_iack: assert property (p_iack) else $error("interrupt not acknowledged"); // see [R18]

  c_read: cover property (@(posedge lnk_clk_i) st_q == ST_WAIT && !s2_q.ack_n && read_o);
  c_write: cover property (@(posedge lnk_clk_i) st_q == ST_WAIT && !s2_q.ack_n && !read_o);
  c_legacy: cover property (@(posedge lnk_clk_i) $fell(legacy_cycle_valid_n_o));
  c_grant: cover property (@(posedge lnk_clk_i) !grant_chain_in_n_o ##[1:8] dma_active_o);
endmodule
`default_nettype wire

//--- rtl/esb_pkg.sv
// esb_pkg: shared constants, carriers and states for the expansion slot host.
// assumes a 200 MHz system clock and a separate processor (link) clock.
`default_nettype none
package esb_pkg;
  localparam int ESB_NSLOT = 3;
  localparam int ESB_DW = 16;
  localparam int ESB_AW = 12;
  // clock figures, in nanoseconds and system clocks
  localparam int ESB_CLK_PERIOD_NS = 5;
  localparam int ESB_LNK_PERIOD_NS = 125;
  localparam int ESB_REF_HALF_NS = 100;
  localparam int ESB_REF_HALF_CYC = ESB_REF_HALF_NS / ESB_CLK_PERIOD_NS;
  localparam logic [4:0] ESB_REF_LAST = 5'(ESB_REF_HALF_CYC - 1);
  // legacy E clock, in processor clocks
  localparam int ESB_E_HI_CYC = 4;
  localparam int ESB_E_LO_CYC = 6;
  localparam logic [3:0] ESB_E_HI = 4'(ESB_E_HI_CYC);
  localparam logic [3:0] ESB_E_HI_LAST = 4'(ESB_E_HI_CYC - 1);
  localparam logic [3:0] ESB_E_LAST = 4'(ESB_E_HI_CYC + ESB_E_LO_CYC - 1);
  // no-acknowledge timeout, rounded down to whole link cycles
  localparam int ESB_TMO_MS = 30;
  localparam int ESB_TMO_CYC = ESB_TMO_MS * 1000000 / ESB_LNK_PERIOD_NS;
  // data lines that load the high DMA address byte
  localparam int ESB_DMA_LSB = 5;
  localparam int ESB_DMA_MSB = 12;

  typedef struct packed {
    logic [1:0] slot;
    logic area;
    logic [ESB_AW-1:0] waddr;
    logic wr;
    logic ube;
    logic lbe;
    logic [ESB_DW-1:0] wdata;
  } esb_cmd_t;

  typedef struct packed {
    logic [ESB_DW-1:0] rdata;
    logic berr;
    logic legacy;
  } esb_rsp_t;

  typedef struct packed {
    logic [ESB_DW-1:0] d;
    logic ack_n;
    logic vpa_n;
    logic breq_n;
    logic own_n;
    logic dma_hi_latch_load_n_n;
  } esb_pin_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_SEL = 6'h04,
    ST_WAIT = 6'h08,
    ST_LEG = 6'h10,
    ST_END = 6'h20
  } esb_state_t;
endpackage
`default_nettype wire

//--- verif/esb_card_model.sv
// esb_card_model: behavioural cards for the three slots, one word memory per slot.
// assumes the processor clock, the resolved data wire and the host's slot pins.
`default_nettype none
module esb_card_model import esb_pkg::*; (
  // clock, reset and scenario controls
  input wire logic lnk_clk_i,
  input wire logic brst_n_i,
  input wire logic [1:0] mode_i,
  input wire logic [2:0] irq_req_i,
  input wire logic dma_go_i,
  input wire logic [7:0] dma_byte_i,
  // host pins
  input wire logic [ESB_AW-1:0] addr_i,
  input wire logic [ESB_DW-1:0] data_i,
  input wire logic ubs_n_i,
  input wire logic lbs_n_i,
  input wire logic rd_i,
  input wire logic [2:0] lo_sel_n_i,
  input wire logic [2:0] hi_sel_n_i,
  input wire logic gnt_n_i,
  input wire logic [2:0] irq_ack_n_i,
  // card pins
  output var esb_pin_t pin_o,
  output logic oe_o,
  output logic [2:0] irq_n_o,
  output logic gnt_out_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [3][8192];
  logic [3:0] wait_q;
  logic [2:0] dma_q;
  logic [2:0] acked_q;
  logic rd_oe;
  int s;
  logic [12:0] ix;
  initial begin
    pin_o = '{d: 16'hFFFF, default: 1'b1};
    oe_o = 1'b0;
    irq_n_o = 3'h7;
  end
  // mode 0 answers at once, 1 after six link cycles, 2 with the legacy request, 3 never
  always @(posedge lnk_clk_i) begin
    #1;
    if (!brst_n_i) begin
      pin_o = '{d: 16'hFFFF, default: 1'b1};
      rd_oe = 1'b0;
      wait_q = 4'h0;
      dma_q = 3'h0;
      acked_q = 3'h0;
      irq_n_o = 3'h7;
    end else begin
      s = !(lo_sel_n_i[0] & hi_sel_n_i[0]) ? 0 : !(lo_sel_n_i[1] & hi_sel_n_i[1]) ? 1 : 2;
      ix = {~&hi_sel_n_i, addr_i};
      if (&{lo_sel_n_i, hi_sel_n_i}) begin
        pin_o.ack_n = 1'b1;
        pin_o.vpa_n = 1'b1;
        rd_oe = 1'b0;
        wait_q = 4'h0;
      end else begin
        // upper address lines are only trusted once a select is seen
        if (!rd_i && !ubs_n_i) mem[s][ix][15:8] = data_i[15:8];
        if (!rd_i && !lbs_n_i) mem[s][ix][7:0] = data_i[7:0];
        if (wait_q != 4'hF) wait_q++;
        if (mode_i != 2'h3 && (mode_i != 2'h1 || wait_q >= 4'h6)) begin
          rd_oe = rd_i;
          if (rd_i) pin_o.d = mem[s][ix];
          if (mode_i == 2'h2) pin_o.vpa_n = 1'b0;
          else pin_o.ack_n = 1'b0;
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (!irq_ack_n_i[k]) acked_q[k] = 1'b1;
        if (!irq_req_i[k]) acked_q[k] = 1'b0;
        irq_n_o[k] = !(irq_req_i[k] && !acked_q[k]);
      end
      if (dma_q == 3'h0 && dma_go_i) begin
        pin_o.breq_n = 1'b0;
        dma_q = 3'h1;
      end else if (dma_q == 3'h1 && !gnt_n_i) begin
        pin_o.breq_n = 1'b1;
        pin_o.own_n = 1'b0;
        pin_o.d = {3'h0, dma_byte_i, 5'h00};
        dma_q = 3'h2;
      end else if (dma_q == 3'h2 || dma_q == 3'h3) begin
        pin_o.dma_hi_latch_load_n_n = !pin_o.dma_hi_latch_load_n_n;
        dma_q++;
      end else if (dma_q == 3'h4) begin
        pin_o.own_n = 1'b1;
        dma_q = 3'h5;
      end else if (dma_q == 3'h5 && !dma_go_i) begin
        dma_q = 3'h0;
      end
    end
    oe_o = rd_oe || (dma_q >= 3'h2 && dma_q <= 3'h4);
  end
  assign gnt_out_n_o = (dma_q == 3'h0 && !dma_go_i) ? gnt_n_i : 1'b1;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// tb_top: self-checking bench for the expansion slot host and the card model.
// assumes the card model answers every slot cycle as its mode says.
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb_top import esb_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // short no-acknowledge limit keeps the abandon scenarios quick
  localparam int TMO = 50;
  logic clk_i = 1'b0;
  logic lnk_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cmd_req_i = 1'b0;
  esb_cmd_t cmd_i = '0;
  logic [2:0] irq_ack_i = 3'h0;
  logic [2:0] irq_req = 3'h0;
  logic [1:0] mode = 2'h0;
  logic dma_go = 1'b0;
  logic [7:0] dma_byte = 8'h00;
  logic saw_lcv = 1'b0;
  logic saw_gnt = 1'b0;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  esb_rsp_t rsp;
  esb_pin_t pin;
  logic busy, rsp_v, hoe, astb_n, ubs_n, lbs_n, rd, lcv_n, eclk, gnt_n, dma_act, refclk;
  logic brst_n, card_oe;
  logic [2:0] pend, lo_sel_n, hi_sel_n, irq_ack_n, irq_n;
  logic [11:0] addr;
  logic [15:0] hd, bus_w;
  logic [7:0] dma_hi;
  always #2.5 clk_i = ~clk_i;
  // offset start keeps link edges away from system clock edges
  initial begin
    #1.3;
    forever #62.5 lnk_clk_i = ~lnk_clk_i;
  end
  assign bus_w = hoe ? hd : (card_oe ? pin.d : 16'hFFFF);
  esb_host #(.TMO_CYC(TMO)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .lnk_clk_i(lnk_clk_i),
    .cmd_req_i(cmd_req_i), .cmd_i(cmd_i), .busy_o(busy), .rsp_valid_o(rsp_v), .rsp_o(rsp),
    .irq_ack_i(irq_ack_i), .irq_pending_o(pend),
    .slot_word_address_lines_o(addr), .slot_data_lines_i(bus_w),
    .slot_data_lines_o(hd), .slot_data_lines_oe_o(hoe), .addr_strobe_n_o(astb_n),
    .upper_byte_strobe_n_o(ubs_n), .lower_byte_strobe_n_o(lbs_n), .read_o(rd),
    .transfer_ack_n_i(pin.ack_n), .legacy_periph_req_n_i(pin.vpa_n),
    .legacy_cycle_valid_n_o(lcv_n), .e_clk_o(eclk),
    .slot_low_area_sel_n_o(lo_sel_n), .slot_high_area_sel_n_o(hi_sel_n),
    .bus_req_n_i(pin.breq_n), .grant_chain_in_n_o(gnt_n), .grant_owned_n_i(pin.own_n),
    .dma_hi_latch_load_n_i(pin.dma_hi_latch_load_n_n), .dma_hi_addr_o(dma_hi), .dma_active_o(dma_act),
    .ref_clk_5m_o(refclk), .bus_reset_n_o(brst_n), .slot_irq_n_i(irq_n),
    .slot_irq_ack_n_o(irq_ack_n)
  );
  esb_card_model card (
    .lnk_clk_i(lnk_clk_i), .brst_n_i(brst_n), .mode_i(mode), .irq_req_i(irq_req),
    .dma_go_i(dma_go), .dma_byte_i(dma_byte), .addr_i(addr), .data_i(bus_w),
    .ubs_n_i(ubs_n), .lbs_n_i(lbs_n), .rd_i(rd), .lo_sel_n_i(lo_sel_n),
    .hi_sel_n_i(hi_sel_n), .gnt_n_i(gnt_n), .irq_ack_n_i(irq_ack_n),
    .pin_o(pin), .oe_o(card_oe), .irq_n_o(irq_n), .gnt_out_n_o()
  );
  // falling edge sampling sees settled registers
  always @(negedge clk_i) begin
    cyc++;
    if (rstn_i && !astb_n && rd && hoe) begin
      n_mismatch++;
      $display("ERROR %0t: host drives the data lines on a read", $time);
    end
    if (!lcv_n) saw_lcv = 1'b1;
    if (!gnt_n) saw_gnt = 1'b1;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic edge_step(input bit l);
    if (l) @(posedge lnk_clk_i);
    else @(posedge clk_i);
    #1;
  endtask
  function automatic logic lvl(input bit l);
    return l ? eclk : refclk;
  endfunction
  task automatic measure(input bit l, output int hi, output int lo);
    int i;
    for (i = 0; i < 60 && lvl(l) !== 1'b0; i++) edge_step(l);
    for (i = 0; i < 60 && lvl(l) !== 1'b1; i++) edge_step(l);
    for (hi = 0; hi < 60 && lvl(l) === 1'b1; hi++) edge_step(l);
    for (lo = 0; lo < 60 && lvl(l) === 1'b0; lo++) edge_step(l);
  endtask
  // long enough for four link edges, which the link side needs to leave reset
  task automatic do_reset();
    edge_step(1'b0);
    rstn_i = 1'b0;
    repeat (120) edge_step(1'b0);
    `CHK(brst_n, 1'b0)
    rstn_i = 1'b1;
    repeat (60) edge_step(1'b0);
  endtask
  task automatic do_cmd(input logic [1:0] s, input logic a, input logic [11:0] wa,
                        input logic w, input logic [1:0] be, input logic [15:0] wd,
                        output esb_rsp_t r, output int c);
    int i;
    edge_step(1'b0);
    cmd_i = '{slot: s, area: a, waddr: wa, wr: w, ube: be[1], lbe: be[0], wdata: wd};
    cmd_req_i = 1'b1;
    for (i = 0; i < 50 && busy !== 1'b1; i++) edge_step(1'b0);
    cmd_req_i = 1'b0;
    for (c = 1; c < 4000 && rsp_v !== 1'b1; c++) edge_step(1'b0);
    `CHK(rsp_v, 1'b1)
    r = rsp;
  endtask
  task automatic t_idle();
    `CHK({astb_n, ubs_n, lbs_n, lcv_n, gnt_n}, 5'h1F)
    `CHK({lo_sel_n, hi_sel_n, irq_ack_n}, 9'h1FF)
    `CHK({rd, hoe, busy, dma_act}, 4'h0)
    `CHK(brst_n, 1'b1)
  endtask
  task automatic t_rw();
    esb_rsp_t r;
    int c;
    mode = 2'h0;
    do_cmd(2'h0, 1'b0, 12'h000, 1'b1, 2'h3, 16'h1234, r, c);
    do_cmd(2'h1, 1'b0, 12'hFFF, 1'b1, 2'h3, 16'h1111, r, c);
    do_cmd(2'h1, 1'b1, 12'hFFF, 1'b1, 2'h3, 16'h2222, r, c);
    do_cmd(2'h2, 1'b0, 12'h123, 1'b1, 2'h3, 16'hA5A5, r, c);
    do_cmd(2'h2, 1'b0, 12'h123, 1'b1, 2'h2, 16'h3C00, r, c);
    do_cmd(2'h2, 1'b0, 12'h123, 1'b1, 2'h1, 16'hFF5A, r, c);
    `CHK(r.berr, 1'b0)
    do_cmd(2'h1, 1'b0, 12'hFFF, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK(r.rdata, 16'h1111)
    mode = 2'h1;
    do_cmd(2'h1, 1'b1, 12'hFFF, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK(r.rdata, 16'h2222)
    do_cmd(2'h2, 1'b0, 12'h123, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK({r.rdata, r.legacy}, {16'h3C5A, 1'b0})
  endtask
  task automatic t_legacy();
    esb_rsp_t r;
    int c;
    mode = 2'h2;
    saw_lcv = 1'b0;
    do_cmd(2'h0, 1'b0, 12'h000, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK({r.rdata, r.legacy, saw_lcv}, {16'h1234, 2'h3})
    do_cmd(2'h0, 1'b0, 12'h001, 1'b1, 2'h3, 16'h5AA5, r, c);
    mode = 2'h0;
    saw_lcv = 1'b0;
    do_cmd(2'h0, 1'b0, 12'h001, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK({r.rdata, r.legacy, saw_lcv}, {16'h5AA5, 2'h0})
  endtask
  task automatic t_tmo();
    esb_rsp_t r;
    int c;
    mode = 2'h3;
    do_cmd(2'h0, 1'b0, 12'h000, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK(r.berr, 1'b1)
    `CHK(c >= TMO * 25 && c <= (TMO + 20) * 25, 1'b1)
    mode = 2'h0;
    do_cmd(2'h3, 1'b0, 12'h000, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK(r.berr, 1'b1)
  endtask
  task automatic t_clocks();
    int hi, lo;
    measure(1'b1, hi, lo);
    `CHK({hi, lo}, {32'd4, 32'd6})
    measure(1'b0, hi, lo);
    `CHK({hi, lo}, {32'd20, 32'd20})
  endtask
  task automatic t_irq();
    int i;
    for (int k = 0; k < 3; k++) begin
      irq_req[k] = 1'b1;
      for (i = 0; i < 200 && pend[k] !== 1'b1; i++) edge_step(1'b0);
      `CHK({pend[k], irq_ack_n}, {1'b1, 3'h7})
      irq_ack_i[k] = 1'b1;
      edge_step(1'b0);
      irq_ack_i[k] = 1'b0;
      for (i = 0; i < 10 && irq_ack_n[k] !== 1'b0; i++) edge_step(1'b0);
      `CHK(irq_ack_n, ~(3'h1 << k))
      for (i = 0; i < 400 && irq_ack_n[k] !== 1'b1; i++) edge_step(1'b0);
      `CHK(irq_ack_n[k], 1'b1)
      irq_req[k] = 1'b0;
    end
  endtask
  task automatic t_dma();
    esb_rsp_t r;
    int c;
    dma_byte = 8'hC3;
    dma_go = 1'b1;
    saw_gnt = 1'b0;
    for (c = 0; c < 400 && dma_act !== 1'b1; c++) edge_step(1'b0);
    `CHK({dma_act, saw_gnt}, 2'h3)
    for (c = 0; c < 400 && dma_act !== 1'b0; c++) edge_step(1'b0);
    `CHK({dma_hi, gnt_n}, {8'hC3, 1'b1})
    dma_go = 1'b0;
    do_cmd(2'h0, 1'b0, 12'h000, 1'b0, 2'h3, 16'h0000, r, c);
    `CHK(r.rdata, 16'h1234)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    do_reset();
    t_idle();
    t_rw();
    t_legacy();
    t_tmo();
    t_clocks();
    t_irq();
    t_dma();
    do_reset();
    t_idle();
    wrap_up();
  end
endmodule
`default_nettype wire
